// ---- aoc_cfg_master.sv ----
// Serial configuration master model for the converter port.
// Assumes mclk at 10 MHz; sck half period is four mclk cycles.
`timescale 1ns/1ps
// ================================================================
// Master
module aoc_cfg_master (
    input  wire        mclk,
    input  wire        start,
    input  wire [15:0] frame,
    input  wire        sdoIn,
    output logic       mCsN,
    output logic       mSck,
    output logic       mSdi,
    output logic       busy,
    output logic [7:0] rdData
);
    initial begin
        mCsN = 1'b1;
        mSck = 1'b0;
        mSdi = 1'b0;
        busy = 1'b0;
        rdData = 8'h00;
    end

    task automatic halfBit();
        repeat (4) @(negedge mclk);
    endtask

    // Serial clock stands low between frames
    always @(posedge mclk) begin
        if (start && !busy) begin
            busy = 1'b1;
            @(negedge mclk);
            mCsN = 1'b0;
            for (int i = 15; i >= 0; i--) begin
                mSdi = frame[i];
                halfBit();
                mSck = 1'b1;
                halfBit();
                if (i < 8)
                    rdData[i] = sdoIn;
                mSck = 1'b0;
            end
            halfBit();
            mCsN = 1'b1;
            // Released data line must not keep its last level
            mSdi = ~mSdi;
            busy = 1'b0;
        end
    end
endmodule // aoc_cfg_master

// ---- aoc_output_config_port.v ----
// Output and configuration port logic of a 16-bit sampling converter.
// Assumes all pins asynchronous to mclk and encode, sck far below 5 MHz.
`timescale 1ns/1ps
`include "aoc_regs.vh"

module aoc_output_config_port #(
    parameter LATENCY = 6
) (
    input  wire        mclk,
    input  wire        srst,
    input  wire        progModeSelect,
    input  wire        csN,
    input  wire        sck,
    input  wire        sdi,
    input  wire        sdoIn,
    input  wire        encodePos,
    input  wire        encodeNeg,
    input  wire [15:0] sampleIn,
    input  wire        sampleOvfIn,
    output reg  [15:0] dataOut,
    output reg         dataClockOutP,
    output reg         dataClockOutN,
    output reg         rangeOverflowFlag,
    output reg         sdoOut,
    output reg         sdoOeN,
    output reg         dcsEnable,
    output reg  [1:0]  outputMode,
    output reg  [1:0]  powerDown,
    output reg         napActive,
    output reg         singleEndedEnc,
    output reg  [2:0]  lvdsCurrent,
    output reg         lvdsTermEn
);

    // ================================================================
    // Pin synchronisers
    wire [6:0] pinRaw = {progModeSelect, csN, sck, sdi, sdoIn,
                         encodePos, encodeNeg};
    reg  [6:0] syncA_q;
    reg  [6:0] syncB_q;
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : gSync
            always @(posedge mclk) begin
                if (srst) begin
                    syncA_q[g] <= 1'b0;
                    syncB_q[g] <= 1'b0;
                end else begin
                    syncA_q[g] <= pinRaw[g];
                    syncB_q[g] <= syncA_q[g];
                end
            end
        end
    endgenerate

    wire parMode = syncB_q[6];
    wire csS     = syncB_q[5];
    wire sckS    = syncB_q[4];
    wire sdiS    = syncB_q[3];
    wire sdoS    = syncB_q[2];
    wire encPS   = syncB_q[1];
    wire encNS   = syncB_q[0];

    // ================================================================
    // Mode control registers
    reg  [7:0] powerReg_q;
    reg  [7:0] timingReg_q;
    reg  [7:0] outputReg_q;
    reg  [7:0] readData;
    reg  [6:0] readAddr;

    // Looked up while the address completes; latched on bit eight
    always @* begin
        readData = regRead(readAddr, powerReg_q, timingReg_q,
                           outputReg_q);
    end

    // ================================================================
    // Serial port
    reg        sckPrev_q;
    reg  [4:0] bitCnt_q;
    reg  [15:0] shiftIn_q;
    reg        readMode_q;
    reg  [7:0] readShift_q;

    // Parallel mode ignores the serial clock as a clock; sck then straps the output mode
    wire frameOn = ~parMode & ~csS;
    wire sckRise = frameOn & sckS & ~sckPrev_q;
    wire sckFall = frameOn & ~sckS & sckPrev_q;
    wire [6:0] wrAddr = shiftIn_q[13:7];
    wire [7:0] wrData = {shiftIn_q[6:0], sdiS};
    wire       doWrite = sckRise & (bitCnt_q == `AOC_FRAME_LAST) &
                         ~shiftIn_q[14];

    always @* begin
        readAddr = {shiftIn_q[5:0], sdiS};
    end

    function [7:0] regRead;
        input [6:0] a;
        input [7:0] p;
        input [7:0] t;
        input [7:0] o;
        begin
            case (a)
                `AOC_ADDR_POWER:  regRead = p;
                `AOC_ADDR_TIMING: regRead = t;
                `AOC_ADDR_OUTPUT: regRead = o;
                default:          regRead = 8'h00;
            endcase
        end
    endfunction

    always @(posedge mclk) begin
        if (srst) begin
            sckPrev_q   <= 1'b0;
            bitCnt_q    <= 5'h00;
            shiftIn_q   <= 16'h0000;
            readMode_q  <= 1'b0;
            readShift_q <= 8'hff;
            sdoOeN      <= 1'b1;
            sdoOut      <= 1'b0;
        end else begin
            sckPrev_q <= sckS;
            sdoOut    <= 1'b0;
            if (~frameOn) begin
                // Chip select high aborts any partial frame
                bitCnt_q   <= 5'h00;
                readMode_q <= 1'b0;
                sdoOeN     <= 1'b1;
            end else if (sckRise) begin
                shiftIn_q <= {shiftIn_q[14:0], sdiS};
                if (bitCnt_q != `AOC_FRAME_LAST + 5'h01)
                    bitCnt_q <= bitCnt_q + 5'h01;
                if (bitCnt_q == `AOC_CMD_LAST && shiftIn_q[6]) begin
                    readMode_q  <= 1'b1;
                    readShift_q <= readData;
                end
            end else if (sckFall && readMode_q &&
                         bitCnt_q >= `AOC_DATA_FIRST &&
                         bitCnt_q <= `AOC_FRAME_LAST + 5'h01) begin
                // Release on a one, pull low on a zero
                sdoOeN      <= readShift_q[7];
                readShift_q <= {readShift_q[6:0], 1'b1};
            end
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            powerReg_q  <= `AOC_POWER_RST;
            timingReg_q <= `AOC_TIMING_RST;
            outputReg_q <= `AOC_OUTPUT_RST;
        end else if (doWrite) begin
            case (wrAddr)
                `AOC_ADDR_RESET: begin
                    if (wrData[`AOC_RESET_BIT]) begin
                        powerReg_q  <= `AOC_POWER_RST;
                        timingReg_q <= `AOC_TIMING_RST;
                        outputReg_q <= `AOC_OUTPUT_RST;
                    end
                end
                `AOC_ADDR_POWER:  powerReg_q  <= wrData;
                `AOC_ADDR_TIMING: timingReg_q <= wrData;
                `AOC_ADDR_OUTPUT: outputReg_q <= wrData;
                default: ;
            endcase
        end
    end

    // ================================================================
    // Effective configuration: straps or registers
    reg  [1:0] modeEff;
    reg  [1:0] phaseEff;
    always @* begin
        if (parMode) begin
            modeEff  = sckS ? `AOC_MODE_LVDS : `AOC_MODE_FULL;
            phaseEff = 2'h0;
        end else begin
            modeEff  = outputReg_q[`AOC_MODE_MSB:`AOC_MODE_LSB];
            phaseEff = timingReg_q[`AOC_PHASE_MSB:`AOC_PHASE_LSB];
        end
        if (modeEff == 2'h3)
            modeEff = `AOC_MODE_FULL;
    end
    wire fullRate = (modeEff == `AOC_MODE_FULL);
    wire isLvds   = (modeEff == `AOC_MODE_LVDS);

    // ================================================================
    // Encode edge detection
    reg  [3:0] seCnt_q;
    reg        encPrev_q;
    reg  [2:0] encHist_q;
    reg  [4:0] idleCnt_q;
    // Differential mode fires on pos-over-neg; a grounded neg leaves pos
    wire encLevel = singleEndedEnc ? encPS : (encPS & ~encNS);
    wire encRise  = encLevel & ~encPrev_q;
    wire encFall  = ~encLevel & encPrev_q;
    wire [31:0] napCycles = `AOC_NAP_CYCLES;
    wire [4:0]  napLimit  = napCycles[4:0];

    always @(posedge mclk) begin
        if (srst) begin
            seCnt_q        <= 4'h0;
            singleEndedEnc <= 1'b0;
            encPrev_q      <= 1'b0;
            encHist_q      <= 3'h0;
            idleCnt_q      <= 5'h00;
        end else begin
            encPrev_q <= encLevel;
            encHist_q <= {encHist_q[1:0], encLevel};
            if (encNS) begin
                seCnt_q        <= 4'h0;
                singleEndedEnc <= 1'b0;
            end else if (seCnt_q != `AOC_SE_CYCLES) begin
                seCnt_q <= seCnt_q + 4'h1;
            end else begin
                singleEndedEnc <= 1'b1;
            end
            if (encRise)
                idleCnt_q <= 5'h00;
            else if (idleCnt_q != napLimit)
                idleCnt_q <= idleCnt_q + 5'h01;
        end
    end

    // ================================================================
    // Sample pipeline, one stage per rising encode edge
    reg  [16:0] pipe_q [0:LATENCY-1];
    reg  [16:0] ddrHold_q;
    always @(posedge mclk) begin
        if (srst)
            pipe_q[0] <= 17'h00000;
        else if (encRise)
            pipe_q[0] <= {sampleOvfIn, sampleIn};
    end
    generate
        for (g = 1; g < LATENCY; g = g + 1) begin : gPipe
            always @(posedge mclk) begin
                if (srst)
                    pipe_q[g] <= 17'h00000;
                else if (encRise)
                    pipe_q[g] <= pipe_q[g-1];
            end
        end
    endgenerate
    wire [16:0] pipeOut = pipe_q[LATENCY-1];

    // ================================================================
    // Output lane formatting
    // Odd pins carry the lane; even pins are no-connect or LVDS minus
    reg  [15:0] ddrOdd;
    reg  [15:0] ddrEven;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gLane
            always @* begin
                ddrOdd[2*g+1]  = ddrHold_q[2*g+1];
                ddrEven[2*g+1] = ddrHold_q[2*g];
                // Undriven lane pins idle low in CMOS DDR
                ddrOdd[2*g]  = isLvds & ~ddrHold_q[2*g+1];
                ddrEven[2*g] = isLvds & ~ddrHold_q[2*g];
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (srst) begin
            ddrHold_q         <= 17'h00000;
            dataOut           <= 16'h0000;
            rangeOverflowFlag <= 1'b0;
        end else if (fullRate) begin
            if (encRise) begin
                dataOut           <= pipeOut[15:0];
                rangeOverflowFlag <= pipeOut[16];
            end
        end else if (encRise) begin
            // Odd half of the held word, then capture the next one
            dataOut   <= ddrOdd;
            ddrHold_q <= pipeOut;
        end else if (encFall) begin
            // Half a cycle after capture gives the extra half latency
            dataOut           <= ddrEven;
            rangeOverflowFlag <= ddrHold_q[16];
        end
    end

    // ================================================================
    // Forwarded clock and status
    wire [3:0] encTaps = {encHist_q, encLevel};
    wire       encTap  = encTaps[phaseEff];
    always @(posedge mclk) begin
        if (srst) begin
            dataClockOutP <= 1'b0;
            dataClockOutN <= 1'b1;
            dcsEnable     <= 1'b0;
            outputMode    <= `AOC_MODE_FULL;
            powerDown     <= `AOC_PD_NORMAL;
            napActive     <= 1'b0;
            lvdsCurrent   <= 3'h0;
            lvdsTermEn    <= 1'b0;
        end else begin
            // Full rate falls with the data edge, DDR low on even half
            dataClockOutP <= fullRate ? ~encTap : encTap;
            dataClockOutN <= fullRate ? encTap : ~encTap;
            dcsEnable     <= parMode ? csS :
                             timingReg_q[`AOC_DCS_BIT];
            outputMode    <= modeEff;
            powerDown     <= parMode ? {sdiS, sdoS} :
                             powerReg_q[1:0];
            napActive     <= (idleCnt_q == napLimit);
            lvdsCurrent   <= outputReg_q[`AOC_CUR_MSB:`AOC_CUR_LSB];
            lvdsTermEn    <= outputReg_q[`AOC_TERM_BIT];
        end
    end

endmodule // aoc_output_config_port

// ---- aoc_port_asserts.sv ----
// Checker for the converter output and configuration port.
// Assumes it sees only the top ports and a 10 MHz mclk.
`timescale 1ns/1ps
// ================================================================
// Checker
module aoc_port_asserts (
    input wire        mclk,
    input wire        srst,
    input wire        progModeSelect,
    input wire        csN,
    input wire        sck,
    input wire        encodePos,
    input wire [15:0] dataOut,
    input wire        dataClockOutP,
    input wire        dataClockOutN,
    input wire        sdoOut,
    input wire        sdoOeN,
    input wire        dcsEnable,
    input wire [1:0]  outputMode,
    input wire [2:0]  lvdsCurrent,
    input wire        napActive
);
    logic [5:0] idleCnt_q;
    logic       encPrev_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Any encode change restarts it, so the bound is conservative
    always @(posedge mclk) begin
        encPrev_q <= encodePos;
        if (srst || encodePos != encPrev_q)
            idleCnt_q <= 6'h00;
        else if (idleCnt_q != 6'h3f)
            idleCnt_q <= idleCnt_q + 6'h01;
    end

    a_clock_complement: assert property (
        dataClockOutN == !dataClockOutP) else $error("clock legs equal");
    a_sdo_pull_only: assert property (
        sdoOut == 1'b0) else $error("serial output driven high");
    a_strap_stabilizer: assert property (
        (progModeSelect && $stable(csN)) [*5] |-> dcsEnable == csN)
        else $error("stabilizer strap ignored");
    a_strap_mode: assert property (
        (progModeSelect && $stable(sck)) [*5]
        |-> outputMode == (sck ? 2'h2 : 2'h0))
        else $error("output mode strap ignored");
    a_sdo_release: assert property (
        (!progModeSelect && csN) [*5] |-> sdoOeN)
        else $error("serial output held low while idle");
    a_idle_config: assert property (
        (!progModeSelect && csN) [*6] |-> $stable(outputMode)
        && $stable(dcsEnable) && $stable(lvdsCurrent))
        else $error("settings changed outside a frame");
    a_fullrate_clock: assert property (
        progModeSelect && outputMode == 2'h0 && $past(outputMode) == 2'h0
        && $changed(dataOut) |-> $fell(dataClockOutP))
        else $error("data moved without falling clock");
    a_nap_entry: assert property (
        idleCnt_q >= 6'd26 |-> napActive) else $error("no nap on idle");
endmodule // aoc_port_asserts

bind aoc_output_config_port aoc_port_asserts aoc_port_asserts_i (.*);

// ---- aoc_regs.vh ----
// Constants for the converter output and configuration port.
// Assumes a 10 MHz mclk; included by bare name from the design file.
`ifndef AOC_REGS_VH
`define AOC_REGS_VH

// ================================================================
// Mode control register indices (7-bit serial address)
`define AOC_ADDR_RESET      7'h00
`define AOC_ADDR_POWER      7'h01
`define AOC_ADDR_TIMING     7'h02
`define AOC_ADDR_OUTPUT     7'h03

// ================================================================
// Field positions
`define AOC_RESET_BIT       7
`define AOC_DCS_BIT         0
`define AOC_PHASE_LSB       1
`define AOC_PHASE_MSB       2
`define AOC_MODE_LSB        0
`define AOC_MODE_MSB        1
`define AOC_CUR_LSB         2
`define AOC_CUR_MSB         4
`define AOC_TERM_BIT        5

// ================================================================
// Reset values
`define AOC_POWER_RST       8'h00
`define AOC_TIMING_RST      8'h00
`define AOC_OUTPUT_RST      8'h00

// ================================================================
// Output modes and power states
`define AOC_MODE_FULL       2'h0
`define AOC_MODE_DDRCMOS    2'h1
`define AOC_MODE_LVDS       2'h2
`define AOC_PD_NORMAL       2'h0

// ================================================================
// Serial frame layout
`define AOC_FRAME_LAST      5'h0f
`define AOC_CMD_LAST        5'h07
`define AOC_DATA_FIRST      5'h08

// ================================================================
// Timing: nap when no rising encode edge for one 500 kHz period
`define AOC_MCLK_PERIOD_NS  100
`define AOC_NAP_PERIOD_NS   2000
`define AOC_NAP_CYCLES      (`AOC_NAP_PERIOD_NS / `AOC_MCLK_PERIOD_NS)
`define AOC_SE_CYCLES       8

`endif

// ---- tb_top.sv ----
// Self-checking bench for the converter output and configuration port.
// Assumes the design, checker and master model are compiled first.
`timescale 1ns/1ps
// ================================================================
// Bench
module tb_top;
    logic        mclk, srst, progModeSelect, strapCs, strapSck, strapSdi;
    logic        strapSdo, encodePos, seMode, start, sampleOvfIn;
    logic [15:0] sampleIn, frame;
    logic [31:0] seed;
    logic [16:0] w [0:63];
    int          n_errors, num_checks;
    wire         mCsN, mSck, mSdi, busy, dataClockOutP, dataClockOutN;
    wire         rangeOverflowFlag, sdoOut, sdoOeN, dcsEnable, napActive;
    wire         singleEndedEnc, lvdsTermEn;
    wire [15:0]  dataOut;
    wire [7:0]   rdData;
    wire [2:0]   lvdsCurrent;
    wire [1:0]   outputMode, powerDown;
    wire csN = progModeSelect ? strapCs : mCsN;
    wire sck = progModeSelect ? strapSck : mSck;
    wire sdi = progModeSelect ? strapSdi : mSdi;
    // Pull-up gives the high level when the port releases the pin
    wire sdoIn = progModeSelect ? strapSdo : (sdoOeN ? 1'b1 : sdoOut);
    wire encodeNeg = seMode ? 1'b0 : ~encodePos;

    aoc_output_config_port aoc_output_config_port_i (.*);
    aoc_cfg_master aoc_cfg_master_i (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] lane(input logic [15:0] d, input int s);
        lane = 16'h0000;
        for (int i = 0; i < 8; i++)
            lane[i] = d[2 * i + s];
    endfunction

    task automatic cmpWord(input logic [15:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic cmpBit(input logic got, exp, input string m);
        cmpWord({15'h0000, got}, {15'h0000, exp}, m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic xfer(input logic [15:0] f);
        frame = f;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        for (int g = 0; g < 400 && busy; g++)
            cyc(1);
        cyc(2);
    endtask

    task automatic chk(input logic [16:0] e, input logic hi,
                       input logic [1:0] m);
        if (m == 2'h0) begin
            cmpWord(dataOut, e[15:0], "word");
        end else begin
            cmpBit(dataClockOutP, hi, "clock half");
            cmpWord(lane(dataOut, 1), lane(e[15:0], hi), "lane");
            cmpWord(lane(dataOut, 0), m == 2'h2 ? lane(e[15:0], hi) ^ 16'h00ff
                : 16'h0000, "minus leg");
        end
        cmpBit(rangeOverflowFlag, e[16], "overflow");
    endtask

    // Encode period ten mclk; first eight rises fill the pipeline
    task automatic stream(input int lat, input logic [1:0] m);
        w[0] = {sampleOvfIn, sampleIn};
        for (int k = 0; k < 16; k++) begin
            if (k >= 8)
                chk(w[k - 7], 1'b0, m);
            encodePos = 1'b1;
            cyc(5);
            if (k >= 8)
                chk(w[k - lat], 1'b1, m);
            encodePos = 1'b0;
            seed = lfsr(seed);
            {sampleOvfIn, sampleIn} = seed[16:0];
            w[k + 1] = seed[16:0];
            cyc(5);
        end
        cmpBit(napActive, 1'b0, "nap while running");
        $display("test stream mode %0d done", m);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        {progModeSelect, srst, strapCs, strapSck, strapSdi} = 5'h18;
        {strapSdo, encodePos, seMode, start, sampleOvfIn} = 5'h00;
        sampleIn = 16'h0000;
        frame = 16'h0000;
        seed = 32'hcda2d59f;
        n_errors = 0;
        num_checks = 0;
        cyc(4);
        srst = 1'b0;
        cyc(4);
        for (int c = 0; c < 16; c++) begin
            {strapCs, strapSck, strapSdi, strapSdo} = c[3:0];
            cyc(6);
            cmpBit(dcsEnable, strapCs, "stabilizer strap");
            cmpWord({14'h0, outputMode}, strapSck ? 16'h2 : 16'h0,
                "mode strap");
            cmpWord({14'h0, powerDown}, {14'h0, strapSdi, strapSdo},
                "power strap");
        end
        $display("test strap pins done");
        strapSck = 1'b0;
        cyc(6);
        stream(6, 2'h0);
        cmpBit(singleEndedEnc, 1'b0, "differential encode");
        strapSck = 1'b1;
        cyc(6);
        stream(7, 2'h2);
        progModeSelect = 1'b0;
        cyc(6);
        xfer(16'h0335);
        cmpWord({14'h0, outputMode}, 16'h1, "mode reg");
        cmpWord({13'h0, lvdsCurrent}, 16'h5, "current");
        cmpBit(lvdsTermEn, 1'b1, "termination");
        xfer(16'h0102);
        cmpWord({14'h0, powerDown}, 16'h2, "power reg");
        xfer(16'h8300);
        cmpWord({8'h00, rdData}, 16'h35, "readback");
        xfer(16'h9000);
        cmpWord({8'h00, rdData}, 16'h00, "unmapped read");
        xfer(16'h0201);
        cmpBit(dcsEnable, 1'b1, "stabilizer reg");
        // Phase two: clock rises two mclk after the data edge
        xfer(16'h0205);
        encodePos = 1'b1;
        cyc(3);
        cmpBit(dataClockOutP, 1'b0, "clock delayed");
        cyc(2);
        cmpBit(dataClockOutP, 1'b1, "clock after delay");
        encodePos = 1'b0;
        xfer(16'h0201);
        $display("test serial port done");
        seMode = 1'b1;
        stream(7, 2'h1);
        cmpBit(singleEndedEnc, 1'b1, "single-ended encode");
        cyc(30);
        cmpBit(napActive, 1'b1, "nap on stop");
        xfer(16'h0080);
        xfer(16'h8300);
        cmpWord({8'h00, rdData}, 16'h00, "soft reset");
        cmpWord({14'h0, outputMode}, 16'h0, "mode after reset");
        cmpWord({14'h0, powerDown}, 16'h0, "power after reset");
        $display("test nap and soft reset done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
endmodule // tb_top
